// *** hdl/rx_full_flag_core.sv ***
// Function
// - prescale select in rate bits 6:4, bus-clocked
// - prescaler divides by select plus one
// - divider select bits 2:0 makes bit clock
// - divider divides by two to power n+1
// - rate register readable and writable any time
// - unused status bits read zero, writes ignored
// - receive full sets when transfer completes
// - status read then data read clears receive-full
// - tx empty clears on status read then write
// - data write without armed status read ignored
// - tx empty and enable raise interrupt
// - byte moves to shifter sets tx empty
// - queued byte moves after shift, else stays
// - select low in fault mode sets mode fault
// - status read then control one write clears fault
// - receive or fault interrupt when enabled
// - port disable aborts, empties, resets flags
//
// Implementation choices: the strobed register port and the register addresses.
module rx_full_flag_core
	import rx_full_flag_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic [2:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire logic miso_in,
	input wire logic ss_n_in,
	output logic sck_out,
	output logic mosi_out,
	output logic ss_n_out,
	output logic ss_n_oe_out,
	output logic spi_irq_out,
	output logic irq_out
);
	// ****************************************
	// registers and synchronisers
	// ****************************************
	logic [7:0] ctrl_one_r;
	logic [7:0] ctrl_two_r;
	logic [7:0] rate_r;
	logic [RX_FULL_FLAG_EV_W-1:0] ev_stat_r;
	logic [RX_FULL_FLAG_EV_W-1:0] ev_mask_r;
	logic rxf_r;
	logic txe_r;
	logic mode_fault_flag_r;
	logic rxf_armed_r;
	logic txe_armed_r;
	logic mode_fault_flag_armed_r;
	logic tx_full_r;
	logic [7:0] tx_buf_r;
	logic [7:0] shift_r;
	logic [4:0] edge_cnt_r;
	logic [2:0] pre_cnt_r;
	logic [7:0] div_cnt_r;
	logic miso_s1_r;
	logic miso_s2_r;
	logic ss_s1_r;
	logic ss_s2_r;
	logic ss_prev_r;
	rx_full_flag_state_e state_r;
	logic [7:0] rx_data;

	logic wr_data;
	logic wr_ctrl_one;
	logic rd_status;
	logic rd_data;
	logic port_en;
	logic master;
	logic fault_mode;
	logic half_tick;
	logic load_shift;
	logic xfer_done;
	logic ss_fall;
	logic [RX_FULL_FLAG_EV_W-1:0] ev_set;
	logic [7:0] status_view;

	assign wr_data = reg_wr_in && (reg_addr_in == RX_FULL_FLAG_OFS_DATA);
	assign wr_ctrl_one = reg_wr_in && (reg_addr_in == RX_FULL_FLAG_OFS_CTRL_ONE);
	assign rd_status = reg_rd_in && (reg_addr_in == RX_FULL_FLAG_OFS_STATUS);
	assign rd_data = reg_rd_in && (reg_addr_in == RX_FULL_FLAG_OFS_DATA);
	assign port_en = ctrl_one_r[RX_FULL_FLAG_C1_PORT_EN];
	assign master = ctrl_one_r[RX_FULL_FLAG_C1_MASTER];
	assign fault_mode = master && ctrl_two_r[RX_FULL_FLAG_C2_MODE_FAULT_FLAG_EN]
		&& !ctrl_one_r[RX_FULL_FLAG_C1_SELECT_OUTPUT_ENABLE];
	// the first synchroniser stage feeds only the second
	assign ss_fall = ss_prev_r && !ss_s2_r;

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			miso_s1_r <= 1'b0;
			miso_s2_r <= 1'b0;
			ss_s1_r <= 1'b1;
			ss_s2_r <= 1'b1;
			ss_prev_r <= 1'b1;
		end
		else
		begin
			miso_s1_r <= miso_in;
			miso_s2_r <= miso_s1_r;
			ss_s1_r <= ss_n_in;
			ss_s2_r <= ss_s1_r;
			ss_prev_r <= ss_s2_r;
		end
	end

	// ****************************************
	// control and rate registers
	// ****************************************
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			ctrl_one_r <= RX_FULL_FLAG_RESET_BYTE;
			ctrl_two_r <= RX_FULL_FLAG_RESET_BYTE;
			rate_r <= RX_FULL_FLAG_RESET_BYTE;
			ev_mask_r <= '0;
		end
		else if (reg_wr_in)
		begin
			if (reg_addr_in == RX_FULL_FLAG_OFS_CTRL_ONE)
				ctrl_one_r <= reg_wdata_in;
			else if (reg_addr_in == RX_FULL_FLAG_OFS_CTRL_TWO)
				ctrl_two_r <= reg_wdata_in & RX_FULL_FLAG_C2_MASK;
			else if (reg_addr_in == RX_FULL_FLAG_OFS_RATE)
				rate_r <= reg_wdata_in & RX_FULL_FLAG_RATE_MASK;
			else if (reg_addr_in == RX_FULL_FLAG_OFS_IRQ_MASK)
				ev_mask_r <= reg_wdata_in[RX_FULL_FLAG_EV_W-1:0];
		end
	end

	// ****************************************
	// bit-rate generator
	// ****************************************
	// a new rate takes effect at once, since both compares read rate_r directly, so a mid-transfer
	// write can produce a runt clock phase shorter than either setting
	assign half_tick = (pre_cnt_r == rx_full_flag_pre_last(rate_r[RX_FULL_FLAG_RATE_PRE_HI:RX_FULL_FLAG_RATE_PRE_LO]))
		&& (div_cnt_r >= rx_full_flag_div_half_last(rate_r[RX_FULL_FLAG_RATE_DIV_HI:RX_FULL_FLAG_RATE_DIV_LO]));

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in || state_r != RX_FULL_FLAG_SHIFT)
		begin
			pre_cnt_r <= '0;
			div_cnt_r <= '0;
		end
		else if (pre_cnt_r >= rx_full_flag_pre_last(rate_r[RX_FULL_FLAG_RATE_PRE_HI:RX_FULL_FLAG_RATE_PRE_LO]))
		begin
			pre_cnt_r <= '0;
			if (half_tick)
				div_cnt_r <= '0;
			else
				div_cnt_r <= div_cnt_r + 8'h01;
		end
		else
			pre_cnt_r <= pre_cnt_r + 3'h1;
	end

	// ****************************************
	// shifter and transmit buffer
	// ****************************************
	assign load_shift = tx_full_r && (state_r == RX_FULL_FLAG_IDLE) && master;
	assign xfer_done = (state_r == RX_FULL_FLAG_DONE);

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in || !port_en)
		begin
			state_r <= RX_FULL_FLAG_IDLE;
			tx_full_r <= 1'b0;
			tx_buf_r <= RX_FULL_FLAG_RESET_BYTE;
			shift_r <= RX_FULL_FLAG_RESET_BYTE;
			edge_cnt_r <= '0;
			sck_out <= 1'b0;
			mosi_out <= 1'b0;
		end
		else
		begin
			if (wr_data && txe_armed_r && txe_r)
			begin
				tx_buf_r <= reg_wdata_in;
				tx_full_r <= 1'b1;
			end
			case (state_r)
				RX_FULL_FLAG_IDLE:
				begin
					sck_out <= ctrl_one_r[RX_FULL_FLAG_C1_CPOL];
					if (load_shift)
					begin
						shift_r <= tx_buf_r;
						mosi_out <= tx_buf_r[RX_FULL_FLAG_BITS-1];
						tx_full_r <= 1'b0;
						edge_cnt_r <= '0;
						state_r <= RX_FULL_FLAG_SHIFT;
					end
				end
				RX_FULL_FLAG_SHIFT:
				begin
					if (half_tick)
					begin
						sck_out <= !sck_out;
						edge_cnt_r <= edge_cnt_r + 5'h01;
						if (edge_cnt_r[0])
						begin
							shift_r <= {shift_r[RX_FULL_FLAG_BITS-2:0], miso_s2_r};
							mosi_out <= shift_r[RX_FULL_FLAG_BITS-2];
						end
						if (edge_cnt_r == 5'(RX_FULL_FLAG_EDGES - 1))
							state_r <= RX_FULL_FLAG_DONE;
					end
				end
				RX_FULL_FLAG_DONE:
					state_r <= RX_FULL_FLAG_IDLE;
				default:
					state_r <= RX_FULL_FLAG_IDLE;
			endcase
		end
	end

	// received byte lands in the buffer; on overrun the old byte stays and the new one is dropped
	rx_full_flag_byte_buf u_rx_buf
	(
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.wr_en_in(xfer_done && !rxf_r),
		.wr_data_in(shift_r),
		.rd_data_out(rx_data)
	);

	// ****************************************
	// status flags
	// ****************************************
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in || !port_en)
		begin
			rxf_r <= 1'b0;
			txe_r <= 1'b1;
			mode_fault_flag_r <= 1'b0;
			rxf_armed_r <= 1'b0;
			txe_armed_r <= 1'b0;
			mode_fault_flag_armed_r <= 1'b0;
		end
		else
		begin
			// a status read arms each set flag for its clear access
			if (rd_status)
			begin
				rxf_armed_r <= rxf_r;
				txe_armed_r <= txe_r;
				mode_fault_flag_armed_r <= mode_fault_flag_r;
			end
			// set wins over clear in the same cycle
			if (xfer_done)
				rxf_r <= 1'b1;
			else if (rd_data && rxf_armed_r)
			begin
				rxf_r <= 1'b0;
				rxf_armed_r <= 1'b0;
			end
			if (load_shift)
				txe_r <= 1'b1;
			else if (wr_data && txe_armed_r && txe_r)
			begin
				txe_r <= 1'b0;
				txe_armed_r <= 1'b0;
			end
			if (fault_mode && ss_fall)
				mode_fault_flag_r <= 1'b1;
			else if (wr_ctrl_one && mode_fault_flag_armed_r)
			begin
				mode_fault_flag_r <= 1'b0;
				mode_fault_flag_armed_r <= 1'b0;
			end
		end
	end

	// ****************************************
	// interrupts and pins
	// ****************************************
	assign ev_set[RX_FULL_FLAG_EV_RX_DONE] = xfer_done;
	assign ev_set[RX_FULL_FLAG_EV_TX_MOVE] = load_shift;
	assign ev_set[RX_FULL_FLAG_EV_FAULT] = fault_mode && ss_fall && port_en;

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
			ev_stat_r <= '0;
		else if (reg_wr_in && reg_addr_in == RX_FULL_FLAG_OFS_IRQ_STAT)
			ev_stat_r <= ev_set | (ev_stat_r & ~reg_wdata_in[RX_FULL_FLAG_EV_W-1:0]);
		else
			ev_stat_r <= ev_stat_r | ev_set;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
		begin
			spi_irq_out <= 1'b0;
			irq_out <= 1'b0;
			ss_n_out <= 1'b1;
			ss_n_oe_out <= 1'b0;
		end
		else
		begin
			spi_irq_out <= (txe_r && ctrl_one_r[RX_FULL_FLAG_C1_TX_IE])
				|| ((rxf_r || mode_fault_flag_r) && ctrl_one_r[RX_FULL_FLAG_C1_RX_FAULT_IE]);
			irq_out <= |(ev_stat_r & ev_mask_r);
			ss_n_out <= !(state_r == RX_FULL_FLAG_SHIFT);
			ss_n_oe_out <= port_en && master && ctrl_two_r[RX_FULL_FLAG_C2_MODE_FAULT_FLAG_EN]
				&& ctrl_one_r[RX_FULL_FLAG_C1_SELECT_OUTPUT_ENABLE];
		end
	end

	// ****************************************
	// read port
	// ****************************************
	always_comb
	begin
		status_view = RX_FULL_FLAG_RESET_BYTE;
		status_view[RX_FULL_FLAG_ST_RXF] = rxf_r;
		status_view[RX_FULL_FLAG_ST_TXE] = txe_r;
		status_view[RX_FULL_FLAG_ST_MODE_FAULT_FLAG] = mode_fault_flag_r;
	end

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
			reg_rdata_out <= RX_FULL_FLAG_RESET_BYTE;
		else if (reg_rd_in)
		begin
			if (reg_addr_in == RX_FULL_FLAG_OFS_CTRL_ONE)
				reg_rdata_out <= ctrl_one_r;
			else if (reg_addr_in == RX_FULL_FLAG_OFS_CTRL_TWO)
				reg_rdata_out <= ctrl_two_r;
			else if (reg_addr_in == RX_FULL_FLAG_OFS_RATE)
				reg_rdata_out <= rate_r;
			else if (reg_addr_in == RX_FULL_FLAG_OFS_STATUS)
				reg_rdata_out <= status_view;
			else if (reg_addr_in == RX_FULL_FLAG_OFS_DATA)
				reg_rdata_out <= rx_data;
			else if (reg_addr_in == RX_FULL_FLAG_OFS_IRQ_STAT)
				reg_rdata_out <= {5'h00, ev_stat_r};
			else if (reg_addr_in == RX_FULL_FLAG_OFS_IRQ_MASK)
				reg_rdata_out <= {5'h00, ev_mask_r};
			else
				reg_rdata_out <= RX_FULL_FLAG_RESET_BYTE;
		end
		else
			reg_rdata_out <= RX_FULL_FLAG_RESET_BYTE;
	end
endmodule

// *** hdl/rx_full_flag_pkg.sv ***
package rx_full_flag_pkg;
	// register offsets on the plain register port
	localparam logic [2:0] RX_FULL_FLAG_OFS_CTRL_ONE = 3'h0;
	localparam logic [2:0] RX_FULL_FLAG_OFS_CTRL_TWO = 3'h1;
	localparam logic [2:0] RX_FULL_FLAG_OFS_RATE = 3'h2;
	localparam logic [2:0] RX_FULL_FLAG_OFS_STATUS = 3'h3;
	localparam logic [2:0] RX_FULL_FLAG_OFS_DATA = 3'h4;
	localparam logic [2:0] RX_FULL_FLAG_OFS_IRQ_STAT = 3'h5;
	localparam logic [2:0] RX_FULL_FLAG_OFS_IRQ_MASK = 3'h6;
	// control register one fields
	localparam int RX_FULL_FLAG_C1_RX_FAULT_IE = 7;
	localparam int RX_FULL_FLAG_C1_PORT_EN = 6;
	localparam int RX_FULL_FLAG_C1_TX_IE = 5;
	localparam int RX_FULL_FLAG_C1_MASTER = 4;
	localparam int RX_FULL_FLAG_C1_CPOL = 3;
	localparam int RX_FULL_FLAG_C1_SELECT_OUTPUT_ENABLE = 1;
	// control register two fields
	localparam int RX_FULL_FLAG_C2_MODE_FAULT_FLAG_EN = 4;
	// rate register fields
	localparam int RX_FULL_FLAG_RATE_PRE_HI = 6;
	localparam int RX_FULL_FLAG_RATE_PRE_LO = 4;
	localparam int RX_FULL_FLAG_RATE_DIV_HI = 2;
	localparam int RX_FULL_FLAG_RATE_DIV_LO = 0;
	localparam logic [7:0] RX_FULL_FLAG_RATE_MASK = 8'h77;
	localparam logic [7:0] RX_FULL_FLAG_C2_MASK = 8'h10;
	// status register fields
	localparam int RX_FULL_FLAG_ST_RXF = 7;
	localparam int RX_FULL_FLAG_ST_TXE = 5;
	localparam int RX_FULL_FLAG_ST_MODE_FAULT_FLAG = 4;
	// sticky event bits
	localparam int RX_FULL_FLAG_EV_RX_DONE = 0;
	localparam int RX_FULL_FLAG_EV_TX_MOVE = 1;
	localparam int RX_FULL_FLAG_EV_FAULT = 2;
	localparam int RX_FULL_FLAG_EV_W = 3;
	localparam logic [7:0] RX_FULL_FLAG_RESET_BYTE = 8'h00;
	localparam int RX_FULL_FLAG_BITS = 8;
	localparam int RX_FULL_FLAG_EDGES = 2 * RX_FULL_FLAG_BITS;

	typedef enum logic [1:0]
	{
		RX_FULL_FLAG_IDLE = 2'b00,
		RX_FULL_FLAG_SHIFT = 2'b01,
		RX_FULL_FLAG_DONE = 2'b10
	} rx_full_flag_state_e;

	// prescaler division n+1 minus one, as a terminal count
	function automatic logic [2:0] rx_full_flag_pre_last(input logic [2:0] sel);
		rx_full_flag_pre_last = sel;
	endfunction

	// half of the 2^(n+1) divider, minus one: one serial clock edge per half
	function automatic logic [7:0] rx_full_flag_div_half_last(input logic [2:0] sel);
		rx_full_flag_div_half_last = 8'((9'h001 << sel) - 9'h001);
	endfunction
endpackage

// *** hdl/rx_full_flag_byte_buf.sv ***
module rx_full_flag_byte_buf
	import rx_full_flag_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic wr_en_in,
	input wire logic [7:0] wr_data_in,
	output logic [7:0] rd_data_out
);
	// one-word store; read data come out of a register
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
			rd_data_out <= RX_FULL_FLAG_RESET_BYTE;
		else if (wr_en_in)
			rd_data_out <= wr_data_in;
	end
endmodule

// *** dv/rx_full_flag_checker.sv ***
module rx_full_flag_checker
	import rx_full_flag_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic [2:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic miso_in,
	input wire logic ss_n_in,
	input wire logic sck_out,
	input wire logic mosi_out,
	input wire logic ss_n_out,
	input wire logic ss_n_oe_out,
	input wire logic spi_irq_out,
	input wire logic irq_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] edge_r;
	logic [10:0] half_r;
	logic [7:0] c1_r;
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// ****
	// helper state
	// ****
	// shadow of control one, so enables can be judged from the ports alone
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in)
			c1_r <= 8'h00;
		else if (reg_wr_in && reg_addr_in == RX_FULL_FLAG_OFS_CTRL_ONE)
			c1_r <= reg_wdata_in;
	end
	always_ff @(posedge core_clk_in)
	begin
		if (!rst_n_in || ss_n_out)
		begin
			edge_r <= 5'h00;
			half_r <= 11'h000;
		end
		else if (sck_out != $past(sck_out))
		begin
			edge_r <= edge_r + 5'h01;
			half_r <= 11'h000;
		end
		else
			half_r <= half_r + 11'h001;
	end
	// ****
	// properties
	// ****
	property p_rd_idle;
		!$past(reg_rd_in) |-> reg_rdata_out == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside answer cycle");
	property p_st_bits;
		$past(reg_rd_in && reg_addr_in == RX_FULL_FLAG_OFS_STATUS) |-> (reg_rdata_out & 8'h4f) == 8'h00;
	endproperty
	a_st_bits: assert property (p_st_bits)
		else $error("unused status bit set");
	property p_rate_mask;
		$past(reg_rd_in && reg_addr_in == RX_FULL_FLAG_OFS_RATE) |-> (reg_rdata_out & 8'h88) == 8'h00;
	endproperty
	a_rate_mask: assert property (p_rate_mask)
		else $error("rate spare bit set");
	// half_r counts from the start of the frame until the first clock edge;
	// the slowest setting puts that edge 1023 cycles after select falls
	property p_wake;
		!ss_n_out && edge_r == 5'h00 |-> half_r < 11'h400;
	endproperty
	a_wake: assert property (p_wake)
		else $error("frame without clock");
	property p_edges;
		edge_r <= 5'h10;
	endproperty
	a_edges: assert property (p_edges)
		else $error("too many clock edges");
	property p_half;
		half_r <= 11'h406;
	endproperty
	a_half: assert property (p_half)
		else $error("half period too long");
	property p_rst_out;
		$past(!rst_n_in) |-> ss_n_out && !ss_n_oe_out && !irq_out && !spi_irq_out;
	endproperty
	a_rst_out: assert property (p_rst_out)
		else $error("outputs not idle after reset");
	property p_irq_off;
		$past(!c1_r[RX_FULL_FLAG_C1_TX_IE] && !c1_r[RX_FULL_FLAG_C1_RX_FAULT_IE]) |-> !spi_irq_out;
	endproperty
	a_irq_off: assert property (p_irq_off)
		else $error("interrupt while disabled");
	property p_abort;
		(!c1_r[RX_FULL_FLAG_C1_PORT_EN]) [*3] |-> ss_n_out;
	endproperty
	a_abort: assert property (p_abort)
		else $error("select low while port off");
	c_frame: cover property ($fell(ss_n_out));
	c_irq: cover property ($rose(irq_out));
	c_sirq: cover property ($rose(spi_irq_out));
endmodule

bind rx_full_flag_core rx_full_flag_checker chk_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .miso_in(miso_in),
	.ss_n_in(ss_n_in), .sck_out(sck_out), .mosi_out(mosi_out), .ss_n_out(ss_n_out),
	.ss_n_oe_out(ss_n_oe_out), .spi_irq_out(spi_irq_out), .irq_out(irq_out));

// *** dv/rx_full_flag_peer.sv ***
module rx_full_flag_peer (
	input wire logic clk_in,
	input wire logic sck_in,
	input wire logic mosi_in,
	input wire logic ss_n_in,
	input wire logic ss_oe_in,
	input wire logic fault_in,
	input wire logic [7:0] tx_byte_in,
	output logic miso_out,
	output logic ss_line_out,
	output logic [7:0] rx_byte_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic sck_d = 1'b0;
	logic [7:0] sh = 8'h00;
	logic [4:0] edges = 5'h00;
	logic mosi_d = 1'b0;
	// ****
	// peer slave
	// ****
	// pulled-up select line; a rival master pulls it low
	assign ss_line_out = ss_oe_in ? ss_n_in : !fault_in;
	initial miso_out = 1'b0;
	initial rx_byte_out = 8'h00;
	always @(posedge clk_in)
	begin
		sck_d <= sck_in;
		// the master moves mosi on the edge it samples on, and this model sees
		// that edge a cycle late, so it takes the bit that stood before it
		mosi_d <= mosi_in;
		if (ss_n_in)
		begin
			edges <= 5'h00;
			sh <= tx_byte_in;
			// deselected: keep moving so stale data never looks valid
			miso_out <= !miso_out;
		end
		else if (sck_in != sck_d)
		begin
			edges <= edges + 5'h01;
			if (!edges[0])
			begin
				miso_out <= sh[7];
				sh <= {sh[6:0], 1'b0};
			end
			else
				rx_byte_out <= {rx_byte_out[6:0], mosi_d};
		end
	end
endmodule

// *** dv/tb.sv ***
module tb
	import rx_full_flag_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [2:0] ST = RX_FULL_FLAG_OFS_STATUS;
	localparam logic [2:0] DT = RX_FULL_FLAG_OFS_DATA;
	localparam logic [2:0] C1 = RX_FULL_FLAG_OFS_CTRL_ONE;
	logic core_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [2:0] a = 3'h0;
	logic [7:0] d = 8'h00;
	logic w = 1'b0;
	logic r = 1'b0;
	logic flt = 1'b0;
	logic [7:0] q, prx, v;
	logic mi, ssi, sck, mo, sso, select_output_enable, sirq, irq;
	logic [7:0] rt [3] = '{8'h00, 8'h12, 8'h77};
	int err_count = 0;
	int total_checks = 0;
	int cyc = 0;
	int c;
	always #5 core_clk_in = ~core_clk_in;
	rx_full_flag_core dut_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(a),
		.reg_wdata_in(d), .reg_wr_in(w), .reg_rd_in(r), .reg_rdata_out(q), .miso_in(mi),
		.ss_n_in(ssi), .sck_out(sck), .mosi_out(mo), .ss_n_out(sso), .ss_n_oe_out(select_output_enable),
		.spi_irq_out(sirq), .irq_out(irq));
	rx_full_flag_peer peer_u (.clk_in(core_clk_in), .sck_in(sck), .mosi_in(mo), .ss_n_in(sso),
		.ss_oe_in(select_output_enable), .fault_in(flt), .tx_byte_in(8'ha5), .miso_out(mi),
		.ss_line_out(ssi), .rx_byte_out(prx));
	// ****
	// tasks
	// ****
	task automatic finish_test();
		if (err_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic ck(input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e)
		begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic st(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask
	task automatic wr(input logic [2:0] ad, input logic [7:0] x);
		@(posedge core_clk_in);
		a <= ad;
		d <= x;
		w <= 1'b1;
		st(1);
		w <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] ad, output logic [7:0] x);
		@(posedge core_clk_in);
		a <= ad;
		r <= 1'b1;
		st(1);
		r <= 1'b0;
		x = q;
	endtask
	task automatic rc(input logic [2:0] ad, input logic [7:0] e);
		logic [7:0] x;
		rd(ad, x);
		ck(x, e);
	endtask
	// bounded waits: a stuck clock or select ends in the timeout
	task automatic gap();
		logic s;
		s = sck;
		c = 0;
		while (sck === s && c < 3000)
		begin
			st(1);
			c++;
		end
	endtask
	task automatic wt(input logic x);
		for (int i = 0; i < 20000 && sso !== x; i++)
			st(1);
	endtask
	task automatic fault();
		flt <= 1'b1;
		st(6);
		flt <= 1'b0;
	endtask
	always @(posedge core_clk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			err_count++;
			finish_test();
		end
	end
	// ****
	// scenarios
	// ****
	initial
	begin
		st(2);
		rst_n_in <= 1'b1;
		wr(C1, 8'h50);
		wr(DT, 8'h3c);
		st(4);
		ck(sso, 1'b1);
		rc(ST, 8'h20);
		wr(ST, 8'hff);
		rc(ST, 8'h20);
		wr(RX_FULL_FLAG_OFS_RATE, 8'hff);
		rc(RX_FULL_FLAG_OFS_RATE, 8'h77);
		foreach (rt[i])
		begin
			wr(RX_FULL_FLAG_OFS_RATE, rt[i]);
			wr(DT, 8'h3c);
			st(1);
			rc(ST, 8'h20);
			wt(1'b0);
			gap();
			gap();
			ck(16'(c), (16'(rt[i][6:4]) + 16'h0001) << rt[i][2:0]);
			wt(1'b1);
			st(2);
			rc(ST, 8'ha0);
			rd(DT, v);
		end
		wr(RX_FULL_FLAG_OFS_RATE, 8'h31);
		wr(C1, 8'hd0);
		rc(ST, 8'h20);
		ck(sirq, 1'b0);
		wr(DT, 8'h3c);
		wt(1'b0);
		wt(1'b1);
		st(2);
		ck(sirq, 1'b1);
		ck(prx, 8'h3c);
		rd(DT, v);
		rc(ST, 8'ha0);
		rc(DT, 8'ha5);
		rc(ST, 8'h20);
		wr(C1, 8'h70);
		st(2);
		ck(sirq, 1'b1);
		rd(ST, v);
		wr(DT, 8'h11);
		st(1);
		rc(ST, 8'h20);
		wr(DT, 8'h22);
		rc(ST, 8'h00);
		ck(sirq, 1'b0);
		repeat (16) gap();
		st(3);
		rc(ST, 8'ha0);
		wr(C1, 8'h10);
		st(2);
		rc(ST, 8'h20);
		ck(sso, 1'b1);
		ck(irq, 1'b0);
		wr(RX_FULL_FLAG_OFS_IRQ_MASK, 8'h01);
		st(2);
		ck(irq, 1'b1);
		rc(RX_FULL_FLAG_OFS_IRQ_STAT, 8'h03);
		wr(RX_FULL_FLAG_OFS_IRQ_STAT, 8'h01);
		st(2);
		ck(irq, 1'b0);
		wr(C1, 8'h50);
		fault();
		rc(ST, 8'h20);
		wr(RX_FULL_FLAG_OFS_CTRL_TWO, 8'h10);
		fault();
		wr(C1, 8'h50);
		rc(ST, 8'h30);
		wr(C1, 8'h50);
		rc(ST, 8'h20);
		wr(C1, 8'h5a);
		st(2);
		ck(select_output_enable, 1'b1);
		ck(sck, 1'b1);
		fault();
		rc(ST, 8'h20);
		finish_test();
	end
endmodule
